/* shared/fsc_sram_regs.vh */
// Overview of operation
// [RQ1] Selected load with write high starts read.
// [RQ2] Advance continues read, ignoring selects, write enable.
// [RQ3] Read start with output enable high: dummy.
// [RQ4] Dummy burst read advances address, pins tri-stated.
// [RQ5] Selected load, write low, lane low: write.
// [RQ6] Advance with a lane low continues write.
// [RQ7] Write start, all lanes high: abort, nothing.
// [RQ8] Continued write, lanes high: advance, no write.
// [RQ9] Clock hold high ignores the edge entirely.
// [RQ10] Each hold cycle is a wait state.
// [RQ11] Write is write-enable low; lanes per select.
// [RQ12] Write with both lanes high modifies nothing.
// [RQ13] Any write cycle tri-states data and parity.
// [RQ14] Drivers follow cycle type and output enable.
// [RQ15] Output enable masked during write cycles.
// [RQ16] Read tri-states when disabled or deselected.
// [RQ17] Selected read with enable low drives data.
// [RQ18] Power-up deselected, pins tri-stated, enable ignored.
// [RQ19] Unselected load deselects; advance keeps it deselected.
// [RQ20] Sleep ignores inputs and tri-states the pins.
// [RQ21] Burst order linear or interleaved, two bits.
// [RQ22] Write data latched on edge after address.
// [RQ23] Access type fixed at burst start.
// [RQ24] Controller deselects around sleep entry and exit.
`ifndef FSC_SRAM_REGS_VH
`define FSC_SRAM_REGS_VH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define FSC_ADDR_W      17
`define FSC_DATA_W      16
`define FSC_PAR_W       2
`define FSC_LANES       2
`define FSC_FIFO_DEPTH  4
`define FSC_PIN_W       46

// ------------------------------------------------------------
// Cycle states
// ------------------------------------------------------------
`define FSC_ST_DESEL    2'h0
`define FSC_ST_READ     2'h1
`define FSC_ST_WRITE    2'h2

`endif

/* hw/fsc_burst_step.v */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Burst address low bits from start value and beat count.
// ------------------------------------------------------------
module fsc_burst_step
(
	// Burst position
	input  wire [1:0] start_lo,
	input  wire [1:0] beat,
	// Order select, high for interleaved
	input  wire       interleave,
	// Resulting low address bits
	output wire [1:0] addr_lo
);

	assign addr_lo = interleave ? (start_lo ^ beat) : (start_lo + beat); // RQ21

endmodule

`default_nettype wire

/* hw/fsc_fifo.v */
`timescale 1ns/1ps
`default_nettype none

module fsc_fifo
#(
	parameter W  = 37,
	parameter D  = 4,
	parameter AW = 2
)
(
	// Clock and reset
	input  wire          clk_sys,
	input  wire          rstn,
	// Fill side
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	// Drain side
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);

	localparam [AW:0] DEPTH_C = D[AW:0];

	reg [W-1:0]  mem_ff [0:D-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0]   count_ff;

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (count_ff != DEPTH_C);
	assign out_valid = (count_ff != {(AW+1){1'b0}});
	assign out_data  = mem_ff[rd_ptr_ff];

	always @(posedge clk_sys)
	begin
		if (push)
		begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (push && !pop)
			begin
				count_ff <= count_ff + 1'b1;
			end
			else if (pop && !push)
			begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

/* hw/fsc_cycle_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "fsc_sram_regs.vh"

module fsc_cycle_decode
(
	// Clock and reset
	input  wire                      clk_sys,
	input  wire                      rstn,
	// Control pins
	input  wire                      clk_hold_n,
	input  wire                      chip_sel_a_n,
	input  wire                      chip_sel_b,
	input  wire                      chip_sel_c_n,
	input  wire                      sleep_req,
	input  wire                      advance_not_load,
	input  wire                      write_en_n,
	input  wire                      byte_sel_lane_a_n,
	input  wire                      byte_sel_lane_b_n,
	input  wire                      out_en_n,
	input  wire                      burst_mode,
	// Address pins
	input  wire [`FSC_ADDR_W-1:0]    addr,
	// Data and parity pins
	input  wire [`FSC_DATA_W-1:0]    data_in,
	input  wire [`FSC_PAR_W-1:0]     parity_in,
	output reg  [`FSC_DATA_W-1:0]    data_out_ff,
	output reg  [`FSC_PAR_W-1:0]     parity_out_ff,
	output reg                       data_oe_n_ff,
	// Array read port
	output reg                       mem_rd_en_ff,
	output reg  [`FSC_ADDR_W-1:0]    mem_rd_addr_ff,
	input  wire [`FSC_DATA_W-1:0]    mem_rdata,
	input  wire [`FSC_PAR_W-1:0]     mem_rparity,
	// Array write port
	output reg                       mem_wr_en_ff,
	output reg  [`FSC_ADDR_W-1:0]    mem_wr_addr_ff,
	output reg  [`FSC_LANES-1:0]     mem_wr_be_ff,
	output reg  [`FSC_DATA_W-1:0]    mem_wr_data_ff,
	output reg  [`FSC_PAR_W-1:0]     mem_wr_parity_ff,
	input  wire                      mem_wr_ack
);

	// Queue word: address, lanes, data, parity, most significant first.
	localparam FIFO_W = `FSC_ADDR_W + `FSC_LANES + `FSC_DATA_W + `FSC_PAR_W;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	reg  [`FSC_PIN_W-1:0] sync1_ff;
	reg  [`FSC_PIN_W-1:0] sync2_ff;

	// Data pins pass the same two stages, so the fields of a pin cycle stay aligned.
	wire [`FSC_PIN_W-1:0] pin_vec = {out_en_n, burst_mode, sleep_req, clk_hold_n,
	                                 advance_not_load, write_en_n, chip_sel_a_n,
	                                 chip_sel_b, chip_sel_c_n, byte_sel_lane_b_n,
	                                 byte_sel_lane_a_n, addr, parity_in, data_in};

	always @(posedge clk_sys)
	begin
		sync1_ff <= pin_vec;
		sync2_ff <= sync1_ff;
	end

	wire                   s_oe_n    = sync2_ff[45];
	wire                   s_mode    = sync2_ff[44];
	wire                   s_sleep   = sync2_ff[43];
	wire                   s_hold    = sync2_ff[42];
	wire                   s_adv     = sync2_ff[41];
	wire                   s_we_n    = sync2_ff[40];
	wire                   s_cs_a_n  = sync2_ff[39];
	wire                   s_cs_b    = sync2_ff[38];
	wire                   s_cs_c_n  = sync2_ff[37];
	wire                   s_bsb_n   = sync2_ff[36];
	wire                   s_bsa_n   = sync2_ff[35];
	wire [`FSC_ADDR_W-1:0] s_addr    = sync2_ff[34:18];
	wire [`FSC_PAR_W-1:0]  s_parity  = sync2_ff[17:16];
	wire [`FSC_DATA_W-1:0] s_data    = sync2_ff[15:0];

	// ------------------------------------------------------------
	// Cycle qualification
	// ------------------------------------------------------------
	wire                  fifo_in_ready;
	wire                  selected  = ~s_cs_a_n & s_cs_b & ~s_cs_c_n;
	wire [`FSC_LANES-1:0] lanes     = ~{s_bsb_n, s_bsa_n}; // RQ11
	wire                  any_lane  = |lanes; // RQ12

	// A held edge or a full write queue freezes the burst state and stops reads; a sleeping device deselects.
	wire step_en = ~s_hold & ~s_sleep & fifo_in_ready; // RQ9 RQ10 RQ20

	// ------------------------------------------------------------
	// Burst state
	// ------------------------------------------------------------
	reg  [1:0]             state_ff;
	reg  [`FSC_ADDR_W-1:0] base_ff;
	reg  [1:0]             beat_ff;
	reg                    wr_pend_ff;
	reg  [`FSC_ADDR_W-1:0] wr_addr_ff;
	reg  [`FSC_LANES-1:0]  wr_lanes_ff;
	reg                    rd_valid_ff;

	reg  [1:0]             nxt_state;
	reg  [`FSC_ADDR_W-1:0] nxt_base;
	reg  [1:0]             nxt_beat;
	reg                    nxt_wr_pend;
	reg  [`FSC_ADDR_W-1:0] nxt_wr_addr;
	reg  [`FSC_LANES-1:0]  nxt_wr_lanes;
	reg                    nxt_rd_en;
	reg  [`FSC_ADDR_W-1:0] nxt_rd_addr;

	// ------------------------------------------------------------
	// Burst address
	// ------------------------------------------------------------
	// The low two address bits wrap within the burst; the rest keep the loaded value.
	wire [1:0]             next_lo;
	wire [1:0]             beat_inc  = beat_ff + 2'h1;
	wire [`FSC_ADDR_W-1:0] next_addr = {base_ff[`FSC_ADDR_W-1:2], next_lo};

	fsc_burst_step i_fsc_burst_step
	(
		.start_lo   (base_ff[1:0]),
		.beat       (beat_inc),
		.interleave (s_mode),
		.addr_lo    (next_lo)
	);

	// ------------------------------------------------------------
	// Next cycle decode
	// ------------------------------------------------------------
	// Chip selects and write enable count only on a load; an advance follows the burst type.
	always @*
	begin
		nxt_state    = state_ff;
		nxt_base     = base_ff;
		nxt_beat     = beat_ff;
		nxt_wr_pend  = 1'b0;
		nxt_wr_addr  = wr_addr_ff;
		nxt_wr_lanes = wr_lanes_ff;
		nxt_rd_en    = 1'b0;
		nxt_rd_addr  = mem_rd_addr_ff;
		if (!s_adv)
		begin
			if (selected)
			begin
				nxt_base = s_addr;
				nxt_beat = 2'h0;
				if (s_we_n)
				begin
					nxt_state   = `FSC_ST_READ; // RQ1 RQ23
					nxt_rd_en   = 1'b1; // RQ3
					nxt_rd_addr = s_addr;
				end
				else
				begin
					nxt_state    = `FSC_ST_WRITE; // RQ5 RQ23
					nxt_wr_pend  = any_lane; // RQ7
					nxt_wr_addr  = s_addr;
					nxt_wr_lanes = lanes;
				end
			end
			else
			begin
				nxt_state = `FSC_ST_DESEL; // RQ19
			end
		end
		else
		begin
			case (state_ff)
				`FSC_ST_READ:
				begin
					nxt_beat    = beat_inc; // RQ2 RQ4
					nxt_rd_en   = 1'b1;
					nxt_rd_addr = next_addr;
				end
				`FSC_ST_WRITE:
				begin
					nxt_beat     = beat_inc; // RQ6 RQ8
					nxt_wr_pend  = any_lane;
					nxt_wr_addr  = next_addr;
					nxt_wr_lanes = lanes;
				end
				default:
				begin
					nxt_state = `FSC_ST_DESEL; // RQ19
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Write data queue
	// ------------------------------------------------------------
	wire [`FSC_DATA_W-1:0] lane_mask = {{8{wr_lanes_ff[1]}}, {8{wr_lanes_ff[0]}}};
	wire                   push      = step_en & wr_pend_ff; // RQ22
	wire [FIFO_W-1:0]      push_word = {wr_addr_ff, wr_lanes_ff, s_data & lane_mask,
	                                    s_parity & wr_lanes_ff};
	wire                   fifo_out_valid;
	wire [FIFO_W-1:0]      fifo_out_data;
	wire                   pop       = fifo_out_valid & (~mem_wr_en_ff | mem_wr_ack);

	// ------------------------------------------------------------
	// Write queue word fields
	// ------------------------------------------------------------
	wire [`FSC_ADDR_W-1:0] q_addr    = fifo_out_data[FIFO_W-1:FIFO_W-`FSC_ADDR_W];
	wire [`FSC_LANES-1:0]  q_lanes   = fifo_out_data[19:18];
	wire [`FSC_DATA_W-1:0] q_data    = fifo_out_data[17:2];
	wire [`FSC_PAR_W-1:0]  q_parity  = fifo_out_data[1:0];

	// A full queue stalls decoding; the host must not write faster than the array drains.
	fsc_fifo
	#(
		.W  (FIFO_W),
		.D  (`FSC_FIFO_DEPTH),
		.AW (2)
	)
	i_fsc_fifo
	(
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// Sequencing registers
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			state_ff       <= `FSC_ST_DESEL; // RQ18
			base_ff        <= {`FSC_ADDR_W{1'b0}};
			beat_ff        <= 2'h0;
			wr_pend_ff     <= 1'b0;
			wr_addr_ff     <= {`FSC_ADDR_W{1'b0}};
			wr_lanes_ff    <= {`FSC_LANES{1'b0}};
			mem_rd_en_ff   <= 1'b0;
			mem_rd_addr_ff <= {`FSC_ADDR_W{1'b0}};
		end
		else if (s_sleep)
		begin
			// A pending write beat and a read in flight are dropped on sleep entry; queued writes still drain.
			state_ff     <= `FSC_ST_DESEL; // RQ20
			wr_pend_ff   <= 1'b0;
			mem_rd_en_ff <= 1'b0;
		end
		else if (step_en)
		begin
			state_ff       <= nxt_state;
			base_ff        <= nxt_base;
			beat_ff        <= nxt_beat;
			wr_pend_ff     <= nxt_wr_pend;
			wr_addr_ff     <= nxt_wr_addr;
			wr_lanes_ff    <= nxt_wr_lanes;
			mem_rd_en_ff   <= nxt_rd_en;
			mem_rd_addr_ff <= nxt_rd_addr;
		end
		else
		begin
			// A held edge leaves the address and the burst type as they are.
			mem_rd_en_ff <= 1'b0; // RQ9
		end
	end

	// ------------------------------------------------------------
	// Array write port
	// ------------------------------------------------------------
	// The request and its fields hold until the array acknowledges.
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			mem_wr_en_ff     <= 1'b0;
			mem_wr_addr_ff   <= {`FSC_ADDR_W{1'b0}};
			mem_wr_be_ff     <= {`FSC_LANES{1'b0}};
			mem_wr_data_ff   <= {`FSC_DATA_W{1'b0}};
			mem_wr_parity_ff <= {`FSC_PAR_W{1'b0}};
		end
		else if (pop)
		begin
			mem_wr_en_ff     <= 1'b1;
			mem_wr_addr_ff   <= q_addr;
			mem_wr_be_ff     <= q_lanes;
			mem_wr_data_ff   <= q_data;
			mem_wr_parity_ff <= q_parity;
		end
		else if (mem_wr_ack)
		begin
			mem_wr_en_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read data capture
	// ------------------------------------------------------------
	// Read data stands until the next beat of a read burst.
	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			rd_valid_ff   <= 1'b0;
			data_out_ff   <= {`FSC_DATA_W{1'b0}};
			parity_out_ff <= {`FSC_PAR_W{1'b0}};
		end
		else if (mem_rd_en_ff)
		begin
			rd_valid_ff   <= 1'b1;
			data_out_ff   <= mem_rdata;
			parity_out_ff <= mem_rparity;
		end
		else if (state_ff != `FSC_ST_READ)
		begin
			rd_valid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Output drivers
	// ------------------------------------------------------------
	// Drive only a selected read with data and output enable low; a write or a
	// deselect in the current cycle always masks output enable.
	wire read_cycle = (state_ff == `FSC_ST_READ); // RQ13 RQ15 RQ16
	wire drive_ok   = rd_valid_ff & read_cycle & ~s_oe_n & ~s_sleep; // RQ14 RQ17

	always @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			data_oe_n_ff <= 1'b1; // RQ18
		end
		else
		begin
			data_oe_n_ff <= ~drive_ok;
		end
	end

endmodule

`default_nettype wire

/* sim/fsc_cycle_decode_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsc_sram_regs.vh"

// ------------------------------------------------------------
// Port checks of the cycle decoder.
// ------------------------------------------------------------
module fsc_cycle_decode_props
(
	// Clock and reset
	input wire logic                   clk_sys,
	input wire logic                   rstn,
	// Control pins
	input wire logic                   clk_hold_n,
	input wire logic                   chip_sel_a_n,
	input wire logic                   sleep_req,
	input wire logic                   advance_not_load,
	input wire logic                   write_en_n,
	input wire logic                   out_en_n,
	input wire logic                   data_oe_n_ff,
	// Array ports
	input wire logic                   mem_rd_en_ff,
	input wire logic                   mem_wr_en_ff,
	input wire logic [`FSC_ADDR_W-1:0] mem_wr_addr_ff,
	input wire logic [`FSC_LANES-1:0]  mem_wr_be_ff,
	input wire logic [`FSC_DATA_W-1:0] mem_wr_data_ff,
	input wire logic [`FSC_PAR_W-1:0]  mem_wr_parity_ff,
	input wire logic                   mem_wr_ack
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_reset_idle: assert property (disable iff (1'b0)
		!rstn |=> data_oe_n_ff && !mem_rd_en_ff && !mem_wr_en_ff)
		else $error("Outputs active after reset.");
	a_sleep_quiet: assert property (
		sleep_req [*5] |-> data_oe_n_ff && !mem_rd_en_ff)
		else $error("Activity during sleep.");
	a_oe_off_tri: assert property (
		out_en_n [*5] |-> data_oe_n_ff)
		else $error("Pins driven with output enable high.");
	a_write_tri: assert property (
		(!advance_not_load && !write_en_n && !clk_hold_n && !sleep_req) [*5] |-> data_oe_n_ff)
		else $error("Pins driven in write cycles.");
	a_hold_no_read: assert property (
		clk_hold_n [*4] |-> !mem_rd_en_ff)
		else $error("Read issued on a held edge.");
	a_desel_no_read: assert property (
		(!advance_not_load && chip_sel_a_n && !clk_hold_n) [*5]
		|-> !mem_rd_en_ff && data_oe_n_ff)
		else $error("Activity while deselected.");
	a_wr_wait_ack: assert property (
		mem_wr_en_ff && !mem_wr_ack |=> mem_wr_en_ff && $stable(mem_wr_addr_ff)
		&& $stable(mem_wr_data_ff))
		else $error("Write request changed before acknowledge.");
	a_wr_some_lane: assert property (
		mem_wr_en_ff |-> mem_wr_be_ff != 2'h0)
		else $error("Write issued with no lane.");
	a_wr_lane_zero: assert property (
		mem_wr_en_ff |-> (mem_wr_data_ff & ~{{8{mem_wr_be_ff[1]}}, {8{mem_wr_be_ff[0]}}}) == 16'h0
		&& (mem_wr_parity_ff & ~mem_wr_be_ff) == 2'h0)
		else $error("Unwritten lane not zero.");
endmodule

bind fsc_cycle_decode fsc_cycle_decode_props i_fsc_cycle_decode_props (.clk_sys, .rstn,
	.clk_hold_n, .chip_sel_a_n, .sleep_req, .advance_not_load, .write_en_n, .out_en_n,
	.data_oe_n_ff, .mem_rd_en_ff, .mem_wr_en_ff, .mem_wr_addr_ff, .mem_wr_be_ff,
	.mem_wr_data_ff, .mem_wr_parity_ff, .mem_wr_ack);
`default_nettype wire

/* sim/fsc_array_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Storage array: read data is a pattern of the address, write
// acknowledge comes at once or after two wait cycles.
// ------------------------------------------------------------
module fsc_array_model
(
	// Clock and reset
	input wire logic         clk_sys,
	input wire logic         rstn,
	// Read port
	input wire logic [16:0]  rd_addr,
	output logic     [15:0]  rdata,
	output logic     [1:0]   rparity,
	// Write port
	input wire logic         wr_en,
	input wire logic         slow,
	output logic             wr_ack
);
	logic [1:0] wait_ff;

	assign rdata = rd_addr[15:0] ^ 16'h5a5a;
	assign rparity = rd_addr[1:0];
	assign wr_ack = wr_en && (!slow || wait_ff == 2'h2);

	always @(posedge clk_sys)
		if (!rstn || !wr_en || wr_ack)
			wait_ff <= 2'h0;
		else
			wait_ff <= wait_ff + 2'h1;
endmodule
`default_nettype wire

/* sim/fsc_cycle_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsc_sram_regs.vh"

`define CHK(n, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			failures++; \
			$display("wrong value %s expected %h seen %h", n, e, g); \
		end \
	end

module fsc_cycle_decode_tb;
	// ------------------------------------------------------------
	// Pins, array and scoreboard.
	// ------------------------------------------------------------
	logic clk_sys = 0, rstn = 0, clk_hold_n = 0, chip_sel_a_n = 1, chip_sel_b = 1;
	logic chip_sel_c_n = 0, sleep_req = 0, advance_not_load = 0, write_en_n = 1;
	logic byte_sel_lane_a_n = 1, byte_sel_lane_b_n = 1, out_en_n = 0, burst_mode = 0;
	logic slow = 0;
	logic [16:0] addr = 0, mem_rd_addr_ff, mem_wr_addr_ff;
	logic [15:0] data_in = 0, data_out_ff, mem_rdata, mem_wr_data_ff;
	logic [1:0]  parity_in = 0, parity_out_ff, mem_rparity, mem_wr_be_ff, mem_wr_parity_ff;
	logic        data_oe_n_ff, mem_rd_en_ff, mem_wr_en_ff, mem_wr_ack;
	logic [16:0] rq[$];
	logic [36:0] wq[$];
	int          failures = 0, n_checks = 0;

	fsc_cycle_decode i_fsc_cycle_decode (.*);
	fsc_array_model i_fsc_array_model (.clk_sys, .rstn, .rd_addr(mem_rd_addr_ff),
		.rdata(mem_rdata), .rparity(mem_rparity), .wr_en(mem_wr_en_ff), .slow,
		.wr_ack(mem_wr_ack));

	always #10 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
	begin
		if (mem_rd_en_ff)
			rq.push_back(mem_rd_addr_ff);
		if (mem_wr_en_ff && mem_wr_ack)
			wq.push_back({mem_wr_addr_ff, mem_wr_be_ff, mem_wr_parity_ff, mem_wr_data_ff});
	end

	task beat(input logic s, input logic adv, input logic we, input logic [1:0] bn,
		input logic [16:0] a, input logic [17:0] d);
		{chip_sel_a_n, advance_not_load, write_en_n, byte_sel_lane_b_n, byte_sel_lane_a_n,
			addr, parity_in, data_in} = {!s, adv, we, bn, a, d};
		@(posedge clk_sys);
		#1;
	endtask

	task idle(input int n);
		repeat (n) beat(0, 0, 1, 2'h3, 17'h0, 18'h0);
	endtask

	task t_read(input logic m);
		logic [16:0] e;
		burst_mode = m;
		rq.delete();
		beat(1, 0, 1, 2'h3, 17'h10a41, 18'h0);
		beat(0, 1, 0, 2'h3, 17'h0, 18'h0);
		clk_hold_n = 1;
		beat(0, 1, 1, 2'h3, 17'h0, 18'h0);
		clk_hold_n = 0;
		beat(0, 1, 0, 2'h3, 17'h0, 18'h0);
		beat(0, 1, 1, 2'h3, 17'h0, 18'h0);
		clk_hold_n = 1;
		idle(8);
		`CHK("reads", 4, rq.size())
		`CHK("rd_start", 17'h10a41, rq[0])
		for (int k = 0; k < 4; k++)
		begin
			e = 17'h10a41;
			e[1:0] = m ? e[1:0] ^ k[1:0] : e[1:0] + k[1:0];
			`CHK("rd_addr", e, rq[k])
		end
		`CHK("data", e[15:0] ^ 16'h5a5a, data_out_ff)
		`CHK("parity", e[1:0], parity_out_ff)
		`CHK("oe_n", 1'b0, data_oe_n_ff)
		out_en_n = 1;
		idle(5);
		`CHK("oe_n", 1'b1, data_oe_n_ff)
		out_en_n = 0;
		clk_hold_n = 0;
		idle(6);
		`CHK("oe_n", 1'b1, data_oe_n_ff)
		`CHK("reads", 4, rq.size())
	endtask

	task t_dummy;
		out_en_n = 1;
		burst_mode = 0;
		idle(3);
		rq.delete();
		beat(1, 0, 1, 2'h3, 17'h00ff2, 18'h0);
		beat(0, 1, 1, 2'h3, 17'h0, 18'h0);
		clk_hold_n = 1;
		idle(6);
		`CHK("oe_n", 1'b1, data_oe_n_ff)
		clk_hold_n = 0;
		out_en_n = 0;
		idle(2);
		`CHK("reads", 2, rq.size())
		`CHK("rd_addr", 17'h00ff3, rq[1])
	endtask

	task t_write;
		slow = 1;
		wq.delete();
		beat(1, 0, 0, 2'h2, 17'h0a5c4, 18'h0);
		beat(0, 1, 1, 2'h0, 17'h0, 18'h1a5b4);
		beat(0, 1, 1, 2'h3, 17'h0, 18'h2c3d2);
		beat(0, 1, 1, 2'h1, 17'h0, 18'h3ffff);
		repeat (5) beat(1, 0, 0, 2'h3, 17'h1, 18'h0b00f);
		idle(30);
		slow = 0;
		`CHK("writes", 3, wq.size())
		`CHK("wr0", {17'h0a5c4, 2'h1, 2'h1, 16'h00b4}, wq[0])
		`CHK("wr1", {17'h0a5c5, 2'h3, 2'h2, 16'hc3d2}, wq[1])
		`CHK("wr3", {17'h0a5c7, 2'h2, 2'h0, 16'hb000}, wq[2])
	endtask

	task t_sleep;
		rq.delete();
		sleep_req = 1;
		repeat (6) beat(1, 0, 1, 2'h3, 17'h3, 18'h0);
		sleep_req = 0;
		idle(6);
		`CHK("reads", 0, rq.size())
		`CHK("oe_n", 1'b1, data_oe_n_ff)
	endtask

	task stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1 rstn = 1;
		idle(2);
		`CHK("oe_n", 1'b1, data_oe_n_ff)
		`CHK("wr_en", 1'b0, mem_wr_en_ff)
		t_read(0);
		t_read(1);
		t_dummy;
		t_write;
		t_sleep;
		stop_test;
	end

	// The tests need about 120 cycles; the limit of 2000 cycles allows over sixteen times that.
	initial
	begin
		#40us;
		failures++;
		stop_test;
	end
endmodule
`default_nettype wire
